//--- rtl/pfc_counters.sv
`timescale 1ns/100ps
`include "pfc_params.svh"

// Summary of operation
// R1: Three-bit code selects 8/10/6/12 bits colour
// R2: New colour depth applied only at vblank
// R3: Depth change needs no pixel clock change
// R4: Software enables dithering on depth mismatch
// R5: Dithering only while dither bit is set
// R6: Two-bit code: spatial or spatio-temporal dither
// R7: Frame counter increments each vblank, wraps
// R8: Flip counter increments each primary flip, wraps
// R9: Vblank captures microsecond counter into stamp
// R10: Flip captures microsecond counter into stamp
// R11: Microsecond rate follows actual clock frequency
// R12: Elapsed counter advances once per microsecond
// R13: Any write clears elapsed counter to zero
// R14: Graphics soft reset keeps elapsed counter
module pfc_counters (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic softRst,
  input wire logic vblankStart,
  input wire logic asyncFlip,
  input wire logic syncFlip,
  input wire logic surfAddrWrite,
  input wire logic [`PFC_CNT_W-1:0] clkCyclesPerUs,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [`PFC_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  output logic regRdValid,
  output pfc_pkg::pfc_depth_t outDepthCode,
  output logic [3:0] outDepthBits,
  output logic ditherActive,
  output pfc_pkg::pfc_dither_t ditherType
);
  import pfc_pkg::*;

  pfc_state_t s_r;
  pfc_state_t s_nxt;
  logic usTick;
  logic [1:0] flipCnt;
  logic wrElapsed;
  logic wrConfig;

  pfc_usec_tick u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .cyclesPerUs(clkCyclesPerUs),
    .usTick(usTick)
  );

  assign flipCnt = pfcFlipCount(asyncFlip, syncFlip, surfAddrWrite);
  assign wrElapsed = regWrEn && (regAddr == `PFC_OFF_ELAPSED_MICROSECONDS);
  assign wrConfig = regWrEn && (regAddr == `PFC_OFF_PIPE_OUTPUT_CONFIG);

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdValid = 1'b0;

    // Elapsed time: soft reset has no effect here
    if (usTick) begin
      s_nxt.elapsed = s_r.elapsed + 32'h00000001; // R12
    end
    if (wrElapsed) begin
      s_nxt.elapsed = `PFC_RST_WORD; // R13
    end

    if (softRst) begin // R14
      s_nxt.frameTotal = `PFC_RST_WORD;
      s_nxt.flipTotal = `PFC_RST_WORD;
      s_nxt.frameStamp = `PFC_RST_WORD;
      s_nxt.flipStamp = `PFC_RST_WORD;
      s_nxt.cfgDepth = `PFC_RST_DEPTH;
      s_nxt.cfgDither = `PFC_RST_DITHER;
      s_nxt.cfgType = `PFC_RST_DITHER_TYPE;
      s_nxt.activeDepth = pfc_depth_t'(`PFC_RST_DEPTH);
      s_nxt.activeBits = pfcDepthBits(`PFC_RST_DEPTH);
    end else begin
      if (vblankStart) begin
        s_nxt.frameTotal = s_r.frameTotal + 32'h00000001; // R7
        s_nxt.frameStamp = s_r.elapsed; // R9
        // Pending depth goes live; reserved codes are not applied
        if (pfcDepthValid(s_r.cfgDepth)) begin // R2 R3
          s_nxt.activeDepth = pfc_depth_t'(s_r.cfgDepth);
          s_nxt.activeBits = pfcDepthBits(s_r.cfgDepth); // R1
        end
      end
      if (flipCnt != 2'h0) begin
        s_nxt.flipTotal = s_r.flipTotal + 32'(flipCnt); // R8
        s_nxt.flipStamp = s_r.elapsed; // R10
      end
      if (wrConfig) begin
        s_nxt.cfgDepth = regWrData[`PFC_CFG_DEPTH_HI:`PFC_CFG_DEPTH_LO]; // R1
        s_nxt.cfgDither = regWrData[`PFC_CFG_DITHER_BIT]; // R5
        s_nxt.cfgType = regWrData[`PFC_CFG_TYPE_HI:`PFC_CFG_TYPE_LO]; // R6
      end
    end

    // Register read, answered one cycle later
    if (regRdEn) begin
      s_nxt.rdValid = 1'b1;
      s_nxt.rdData = `PFC_RST_WORD;
      case (regAddr)
        `PFC_OFF_PIPE_OUTPUT_CONFIG: begin
          s_nxt.rdData[`PFC_CFG_DEPTH_HI:`PFC_CFG_DEPTH_LO] = s_r.cfgDepth;
          s_nxt.rdData[`PFC_CFG_DITHER_BIT] = s_r.cfgDither;
          s_nxt.rdData[`PFC_CFG_TYPE_HI:`PFC_CFG_TYPE_LO] = s_r.cfgType;
        end
        `PFC_OFF_FRAME_TOTAL: s_nxt.rdData = s_r.frameTotal;
        `PFC_OFF_FLIP_TOTAL: s_nxt.rdData = s_r.flipTotal;
        `PFC_OFF_FRAME_CAPTURE_TIME: s_nxt.rdData = s_r.frameStamp;
        `PFC_OFF_FLIP_CAPTURE_TIME: s_nxt.rdData = s_r.flipStamp;
        `PFC_OFF_ELAPSED_MICROSECONDS: s_nxt.rdData = s_r.elapsed;
        default: s_nxt.rdData = `PFC_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r.frameTotal <= `PFC_RST_WORD;
      s_r.flipTotal <= `PFC_RST_WORD;
      s_r.frameStamp <= `PFC_RST_WORD;
      s_r.flipStamp <= `PFC_RST_WORD;
      s_r.elapsed <= `PFC_RST_WORD;
      s_r.cfgDepth <= `PFC_RST_DEPTH;
      s_r.cfgDither <= `PFC_RST_DITHER;
      s_r.cfgType <= `PFC_RST_DITHER_TYPE;
      s_r.activeDepth <= pfc_depth_t'(`PFC_RST_DEPTH);
      s_r.activeBits <= `PFC_BITS_8;
      s_r.rdData <= `PFC_RST_WORD;
      s_r.rdValid <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign regRdData = s_r.rdData;
  assign regRdValid = s_r.rdValid;
  assign outDepthCode = s_r.activeDepth;
  assign outDepthBits = s_r.activeBits;
  // Reserved dither codes disable dithering
  assign ditherActive = s_r.cfgDither && pfcDitherValid(s_r.cfgType); // R5 R6
  assign ditherType = pfc_dither_t'(s_r.cfgType); // R6

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence sFrameEvent;
    vblankStart && !softRst;
  endsequence

  sequence sFlipEvent;
    (flipCnt != 2'h0) && !softRst;
  endsequence

  sequence sDepthWrite;
    wrConfig && !softRst && pfcDepthValid(regWrData[`PFC_CFG_DEPTH_HI:`PFC_CFG_DEPTH_LO]);
  endsequence

  sequence sQuietFrames;
    (!vblankStart && !softRst) [*2];
  endsequence

  a_frame_count_step: assert property (sFrameEvent |=> s_r.frameTotal == $past(s_r.frameTotal) + 32'h00000001) // R7
    else $error("frame counter did not advance by one");

  a_frame_count_hold: assert property ((!vblankStart && !softRst) |=> $stable(s_r.frameTotal)) // R7
    else $error("frame counter moved without vblank");

  a_flip_count_step: assert property (!softRst |=> s_r.flipTotal == $past(s_r.flipTotal) + 32'($past(flipCnt))) // R8
    else $error("flip counter does not match flip events");

  a_frame_stamp_capture: assert property (sFrameEvent |=> s_r.frameStamp == $past(s_r.elapsed)) // R9
    else $error("frame stamp not captured at vblank");

  a_flip_stamp_capture: assert property (sFlipEvent |=> s_r.flipStamp == $past(s_r.elapsed)) // R10
    else $error("flip stamp not captured at flip");

  a_elapsed_clear: assert property (wrElapsed |=> s_r.elapsed == `PFC_RST_WORD) // R13
    else $error("elapsed counter not cleared by write");

  a_elapsed_rate: assert property ((!usTick && !wrElapsed) |=> $stable(s_r.elapsed)) // R12
    else $error("elapsed counter moved without microsecond tick");

  a_elapsed_advance: assert property ((usTick && !wrElapsed) |=> s_r.elapsed == $past(s_r.elapsed) + 32'h00000001) // R12
    else $error("elapsed counter missed a microsecond");

  a_soft_reset_keeps: assert property ((softRst && !usTick && !wrElapsed) |=> s_r.elapsed == $past(s_r.elapsed)) // R14
    else $error("soft reset disturbed elapsed counter");

  a_depth_deferred: assert property ((sDepthWrite ##1 sQuietFrames) |-> $stable(outDepthCode)) // R2
    else $error("colour depth changed before vblank");

  a_depth_applied: assert property ((sDepthWrite ##1 sFrameEvent) |=> outDepthCode == $past(s_r.cfgDepth)) // R2
    else $error("colour depth not applied at vblank");

  a_depth_decode: assert property (outDepthBits == pfcDepthBits(outDepthCode) && outDepthBits != `PFC_BITS_NONE) // R1
    else $error("colour depth bits do not match code");

  a_dither_gate: assert property (!s_r.cfgDither |-> !ditherActive) // R5
    else $error("dithering active while disabled");

  a_dither_reserved: assert property ((s_r.cfgType[1] == 1'b1) |-> !ditherActive) // R6
    else $error("dithering active with reserved type");

  a_read_answer: assert property (regRdEn && (regAddr == `PFC_OFF_FRAME_TOTAL) |=>
    regRdValid && regRdData == $past(s_r.frameTotal)) // R7
    else $error("frame counter read returned wrong value");
endmodule

//--- rtl/pfc_params.svh
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH

// Register byte addresses
`define PFC_ADDR_W 20
`define PFC_OFF_PIPE_OUTPUT_CONFIG 20'h70008
`define PFC_OFF_FRAME_TOTAL 20'h70040
`define PFC_OFF_FLIP_TOTAL 20'h70044
`define PFC_OFF_FRAME_CAPTURE_TIME 20'h70048
`define PFC_OFF_FLIP_CAPTURE_TIME 20'h7004C
`define PFC_OFF_ELAPSED_MICROSECONDS 20'h70070

// Reset values
`define PFC_RST_WORD 32'h00000000
`define PFC_RST_DEPTH 3'h0
`define PFC_RST_DITHER 1'h0
`define PFC_RST_DITHER_TYPE 2'h0

// Output config field positions
`define PFC_CFG_DEPTH_HI 7
`define PFC_CFG_DEPTH_LO 5
`define PFC_CFG_DITHER_BIT 4
`define PFC_CFG_TYPE_HI 3
`define PFC_CFG_TYPE_LO 2
`define PFC_DEPTH_RSVD_BIT 2

// Colour depth codes and bit counts
`define PFC_DEPTH_CODE_8 3'h0
`define PFC_DEPTH_CODE_10 3'h1
`define PFC_DEPTH_CODE_6 3'h2
`define PFC_DEPTH_CODE_12 3'h3
`define PFC_BITS_8 4'h8
`define PFC_BITS_10 4'hA
`define PFC_BITS_6 4'h6
`define PFC_BITS_12 4'hC
`define PFC_BITS_NONE 4'h0

// Dither type codes
`define PFC_DITHER_CODE_SPATIAL 2'h0
`define PFC_DITHER_CODE_ST_ONE 2'h1

// Microsecond timing
`define PFC_CLK_PERIOD_NS 10
`define PFC_US_NS 1000
`define PFC_CNT_W 10
`define PFC_CYCLES_PER_US_DFLT 10'(`PFC_US_NS / `PFC_CLK_PERIOD_NS)

`endif

//--- rtl/pfc_pkg.sv
package pfc_pkg;
  `include "pfc_params.svh"

  typedef enum logic [2:0] {
    PFC_DEPTH_8 = `PFC_DEPTH_CODE_8,
    PFC_DEPTH_10 = `PFC_DEPTH_CODE_10,
    PFC_DEPTH_6 = `PFC_DEPTH_CODE_6,
    PFC_DEPTH_12 = `PFC_DEPTH_CODE_12
  } pfc_depth_t;

  typedef enum logic [1:0] {
    PFC_DITHER_SPATIAL = `PFC_DITHER_CODE_SPATIAL,
    PFC_DITHER_SPATIO_TEMPORAL_ONE = `PFC_DITHER_CODE_ST_ONE
  } pfc_dither_t;

  typedef struct packed {
    logic [31:0] frameTotal;
    logic [31:0] flipTotal;
    logic [31:0] frameStamp;
    logic [31:0] flipStamp;
    logic [31:0] elapsed;
    logic [2:0] cfgDepth;
    logic cfgDither;
    logic [1:0] cfgType;
    pfc_depth_t activeDepth;
    logic [3:0] activeBits;
    logic [31:0] rdData;
    logic rdValid;
  } pfc_state_t;

  typedef struct packed {
    logic [`PFC_CNT_W-1:0] cnt;
    logic tick;
  } pfc_tick_state_t;

  function automatic logic pfcDepthValid(input logic [2:0] code);
    return !code[`PFC_DEPTH_RSVD_BIT];
  endfunction

  function automatic logic [3:0] pfcDepthBits(input logic [2:0] code);
    logic [3:0] bits;
    case (code)
      `PFC_DEPTH_CODE_8: bits = `PFC_BITS_8;
      `PFC_DEPTH_CODE_10: bits = `PFC_BITS_10;
      `PFC_DEPTH_CODE_6: bits = `PFC_BITS_6;
      `PFC_DEPTH_CODE_12: bits = `PFC_BITS_12;
      default: bits = `PFC_BITS_NONE;
    endcase
    return bits;
  endfunction

  function automatic logic [1:0] pfcFlipCount(input logic a, input logic b, input logic c);
    return 2'({1'b0, a} + {1'b0, b} + {1'b0, c});
  endfunction

  function automatic logic pfcDitherValid(input logic [1:0] code);
    return (code == `PFC_DITHER_CODE_SPATIAL) || (code == `PFC_DITHER_CODE_ST_ONE);
  endfunction
endpackage

//--- rtl/pfc_usec_tick.sv
`timescale 1ns/100ps
`include "pfc_params.svh"

module pfc_usec_tick (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`PFC_CNT_W-1:0] cyclesPerUs,
  output logic usTick
);
  import pfc_pkg::*;

  pfc_tick_state_t s_r;
  pfc_tick_state_t s_nxt;
  logic [`PFC_CNT_W-1:0] limit;

  // Zero means the nominal core clock rate
  assign limit = (cyclesPerUs == '0) ? `PFC_CYCLES_PER_US_DFLT : cyclesPerUs;

  always_comb begin
    s_nxt = s_r;
    // Period follows the programmed clock rate
    if (s_r.cnt >= limit - `PFC_CNT_W'(1)) begin // R11
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + `PFC_CNT_W'(1);
      s_nxt.tick = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign usTick = s_r.tick;

  a_tick_single: assert property (@(posedge core_clk) disable iff (rst) // R11
    (usTick && $stable(limit) && limit > `PFC_CNT_W'(1)) |=> !usTick)
    else $error("microsecond tick longer than one cycle");

  a_tick_reload: assert property (@(posedge core_clk) disable iff (rst) // R12
    usTick |-> s_r.cnt == '0)
    else $error("tick without counter reload");
endmodule

//--- test/pfc_counters_tb_top.sv
`timescale 1ns/100ps
`include "pfc_params.svh"

module pfc_counters_tb_top;
  import pfc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic softRst = 1'b0;
  logic vblankStart = 1'b0;
  logic asyncFlip = 1'b0;
  logic syncFlip = 1'b0;
  logic surfAddrWrite = 1'b0;
  logic [`PFC_CNT_W-1:0] clkCyclesPerUs = 10'h000;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [`PFC_ADDR_W-1:0] regAddr = 20'h00000;
  logic [31:0] regWrData = 32'h00000000;
  logic [31:0] regRdData;
  logic regRdValid;
  pfc_depth_t outDepthCode;
  logic [3:0] outDepthBits;
  logic ditherActive;
  pfc_dither_t ditherType;
  int badCount = 0;
  int checked = 0;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] d;
  logic [19:0] offs [6] = '{20'h70040, 20'h70044, 20'h70048, 20'h7004C, 20'h70070, 20'h70008};
  logic [3:0] bitsTab [4] = '{4'h8, 4'hA, 4'h6, 4'hC};
  logic [3:0] flipEv [4] = '{4'h4, 4'h2, 4'h1, 4'h7};
  logic [31:0] flipTot [4] = '{32'h1, 32'h2, 32'h3, 32'h6};
  logic [9:0] rateCpu [3] = '{10'h004, 10'h005, 10'h000};
  int rateWait [3] = '{38, 38, 198};
  logic [31:0] rateExp [3] = '{32'h0000000A, 32'h00000008, 32'h00000002};

  always #5 core_clk = ~core_clk;

  pfc_counters i_pfc_counters (
    .core_clk(core_clk),
    .rst(rst),
    .softRst(softRst),
    .vblankStart(vblankStart),
    .asyncFlip(asyncFlip),
    .syncFlip(syncFlip),
    .surfAddrWrite(surfAddrWrite),
    .clkCyclesPerUs(clkCyclesPerUs),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regRdData(regRdData),
    .regRdValid(regRdValid),
    .outDepthCode(outDepthCode),
    .outDepthBits(outDepthBits),
    .ditherActive(ditherActive),
    .ditherType(ditherType)
  );

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [19:0] addr, input logic [31:0] data);
    @(negedge core_clk);
    regWrEn = 1'b1;
    regAddr = addr;
    regWrData = data;
    @(negedge core_clk);
    regWrEn = 1'b0;
  endtask

  // Read, with {vblank, async, sync, surface write} pulses in the same cycle
  task automatic rdev(input logic [19:0] addr, input logic [3:0] ev, output logic [31:0] q);
    @(negedge core_clk);
    regRdEn = 1'b1;
    regAddr = addr;
    {vblankStart, asyncFlip, syncFlip, surfAddrWrite} = ev;
    @(negedge core_clk);
    regRdEn = 1'b0;
    {vblankStart, asyncFlip, syncFlip, surfAddrWrite} = 4'h0;
    chk("read valid", 32'h1, {31'h0, regRdValid});
    q = regRdData;
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #50000;
    badCount++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    foreach (offs[i]) begin
      rdev(offs[i], 4'h0, a);
      chk("reset value", 32'h0, a);
    end
    chk("reset depth bits", 32'h8, {28'h0, outDepthBits});
    chk("reset dither", 32'h0, {31'h0, ditherActive});
    rdev(20'h70050, 4'h0, a);
    chk("unmapped read", 32'h0, a);
    wr(`PFC_OFF_FRAME_TOTAL, 32'hFFFFFFFF);
    rdev(`PFC_OFF_FRAME_TOTAL, 4'h0, a);
    chk("read-only frame total", 32'h0, a);
    foreach (rateCpu[i]) begin
      clkCyclesPerUs = rateCpu[i];
      repeat (250) @(negedge core_clk);
      rdev(`PFC_OFF_ELAPSED_MICROSECONDS, 4'h0, a);
      repeat (rateWait[i]) @(negedge core_clk);
      rdev(`PFC_OFF_ELAPSED_MICROSECONDS, 4'h0, b);
      chk("elapsed rate", rateExp[i], b - a);
    end
    clkCyclesPerUs = 10'h004;
    for (int i = 1; i <= 3; i++) begin
      rdev(`PFC_OFF_ELAPSED_MICROSECONDS, 4'h8, a);
      rdev(`PFC_OFF_FRAME_CAPTURE_TIME, 4'h0, b);
      chk("frame stamp", a, b);
      rdev(`PFC_OFF_FRAME_TOTAL, 4'h0, b);
      chk("frame total", 32'(i), b);
    end
    foreach (flipEv[i]) begin
      rdev(`PFC_OFF_ELAPSED_MICROSECONDS, flipEv[i], a);
      rdev(`PFC_OFF_FLIP_CAPTURE_TIME, 4'h0, b);
      chk("flip stamp", a, b);
      rdev(`PFC_OFF_FLIP_TOTAL, 4'h0, b);
      chk("flip total", flipTot[i], b);
    end
    for (int j = 1; j <= 4; j++) begin
      d = {24'h000000, 3'(j % 4), 1'b1, 2'(j & 1), 2'b00};
      wr(`PFC_OFF_PIPE_OUTPUT_CONFIG, d);
      chk("dither on", 32'h1, {31'h0, ditherActive});
      chk("dither type", 32'(j & 1), {30'h0, ditherType});
      chk("depth held", {28'h0, bitsTab[(j - 1) % 4]}, {28'h0, outDepthBits});
      rdev(`PFC_OFF_PIPE_OUTPUT_CONFIG, 4'h8, a);
      chk("config readback", d, a);
      chk("depth bits", {28'h0, bitsTab[j % 4]}, {28'h0, outDepthBits});
      chk("depth code", 32'(j % 4), {29'h0, outDepthCode});
    end
    wr(`PFC_OFF_PIPE_OUTPUT_CONFIG, 32'hFFFFFFFF);
    chk("reserved type", 32'h0, {31'h0, ditherActive});
    rdev(`PFC_OFF_PIPE_OUTPUT_CONFIG, 4'h8, a);
    chk("config mask", 32'h000000FC, a);
    chk("reserved depth", 32'h8, {28'h0, outDepthBits});
    wr(`PFC_OFF_PIPE_OUTPUT_CONFIG, 32'h00000004);
    chk("dither off", 32'h0, {31'h0, ditherActive});
    chk("type while off", 32'h1, {30'h0, ditherType});
    rdev(`PFC_OFF_ELAPSED_MICROSECONDS, 4'h0, a);
    @(negedge core_clk);
    softRst = 1'b1;
    @(negedge core_clk);
    softRst = 1'b0;
    rdev(`PFC_OFF_ELAPSED_MICROSECONDS, 4'h0, b);
    chk("elapsed kept", 32'h1, {31'h0, (b >= a) && (b - a <= 32'h2) && (a != 32'h0)});
    rdev(`PFC_OFF_FRAME_TOTAL, 4'h0, b);
    chk("soft reset frames", 32'h0, b);
    // Slow ticks so the readback right after the clear is exact
    clkCyclesPerUs = 10'h3FF;
    repeat (2) @(negedge core_clk);
    wr(`PFC_OFF_ELAPSED_MICROSECONDS, 32'h5A5AA5A5);
    rdev(`PFC_OFF_ELAPSED_MICROSECONDS, 4'h0, a);
    chk("elapsed clear", 32'h0, a);
    report_and_stop();
  end
endmodule
